//--- logic/gcm_pkg.sv
// gcm_pkg: constants for the glitch-free clock selector
// assumes: single 10 MHz system clock, inputs already in its domain
package gcm_pkg;
  // --------------------------------------------------------------
  // select encoding and reset values
  // --------------------------------------------------------------
  localparam logic SEL_A        = 1'b0;
  localparam logic SEL_B        = 1'b1;
  localparam logic SEL_RST      = 1'b1;  // open select reads high
  localparam logic OUT_RST      = 1'b0;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int   CLK_NS       = 100;
  localparam int   POR_NS       = 1600;  // power-on hold time
  localparam int   POR_CYC      = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int   POR_W        = $clog2(POR_CYC + 1);
  localparam int   DC_LIM       = 8;     // cycles without edge = dead
  localparam int   DC_W         = $clog2(DC_LIM + 1);
  // switchover state
  typedef enum logic [1:0] {
    GCM_RUN,
    GCM_WAIT_LOW,
    GCM_WAIT_NEW
  } gcm_state_e;
endpackage : gcm_pkg

//--- logic/gcm_clock_mux.sv
// gcm_clock_mux: 2:1 clock selector with 1:2 fanout and runt suppression
// assumes: clock inputs are sampled, synchronous to mclk_i
// Behaviour
// - pass exactly one of two clocks
// - select low gives A, high gives B
// - two output pairs carry same clock
// - true and complement outputs always opposite
// - no shortened phase during switchover
// - dead selected input holds outputs stable
// - unconnected select reads high, picks B
// - power-on reset initialises switchover logic
// - timing pin tied high disables suppression
`timescale 1ns/1ps
module gcm_clock_mux
  import gcm_pkg::*;
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  // clock inputs
  input  wire logic clk_in_a_i,
  input  wire logic clk_in_b_i,
  // control
  input  wire logic sel_i,
  input  wire logic sel_open_i,
  input  wire logic por_timing_pin_i,
  // outputs
  output logic      clk_out_pair_a_p_o,
  output logic      clk_out_pair_a_n_o,
  output logic      clk_out_pair_b_p_o,
  output logic      clk_out_pair_b_n_o,
  output logic      dc_input_guard_o
);

  // ------------------------------------------------------------
  // selection helpers
  // ------------------------------------------------------------
  function automatic logic pick(input logic s, input logic a,
                                input logic b);
    return (s == SEL_B) ? b : a;
  endfunction : pick

  logic           sel_eff;
  logic           runt_suppress;
  logic           por_done_r;
  logic [POR_W-1:0] por_cnt_r;
  gcm_state_e     state_r;
  logic           cur_sel_r;
  logic           pend_sel_r;
  logic           a_q_r;
  logic           b_q_r;
  logic [DC_W-1:0] dc_cnt_r;
  logic           out_r;
  logic           out_nxt;
  logic           cur_lvl;
  logic           new_lvl;
  logic           dead;
  logic           live;
  logic           hold_dead;
  logic           new_fell;

  assign sel_eff = sel_open_i ? SEL_B : sel_i;
  assign runt_suppress = ~por_timing_pin_i;
  assign cur_lvl = pick(cur_sel_r, clk_in_a_i, clk_in_b_i);
  assign new_lvl = pick(pend_sel_r, clk_in_a_i, clk_in_b_i);
  assign dead    = (dc_cnt_r == DC_W'(DC_LIM));
  // a revived input is followed from its first edge, not one late
  assign live      = (cur_lvl != pick(cur_sel_r, a_q_r, b_q_r));
  assign hold_dead = dead && !live;
  // edge, not level: the new clock's first low phase is whole
  assign new_fell  = !new_lvl && pick(pend_sel_r, a_q_r, b_q_r);

  // ------------------------------------------------------------
  // power-on timer
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      por_cnt_r  <= '0;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r  <= por_cnt_r + POR_W'(1);
      por_done_r <= (por_cnt_r == POR_W'(POR_CYC - 1));
    end
  end

  // ------------------------------------------------------------
  // dead input detector: no edge on selected clock
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a_q_r    <= 1'b0;
      b_q_r    <= 1'b0;
      dc_cnt_r <= '0;
    end else begin
      a_q_r <= clk_in_a_i;
      b_q_r <= clk_in_b_i;
      if (live)
        dc_cnt_r <= '0;
      else if (!dead)
        dc_cnt_r <= dc_cnt_r + DC_W'(1);
    end
  end

  // ------------------------------------------------------------
  // switchover state machine
  // ------------------------------------------------------------
  // parking low costs up to one cycle of each clock, but
  // every emitted phase is full width
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r    <= GCM_RUN;
      cur_sel_r  <= SEL_RST;
      pend_sel_r <= SEL_RST;
    end else if (!por_done_r || !runt_suppress) begin
      state_r    <= GCM_RUN;
      cur_sel_r  <= sel_eff;
      pend_sel_r <= sel_eff;
    end else begin
      unique case (state_r)
        GCM_RUN: begin
          if (sel_eff != cur_sel_r) begin
            pend_sel_r <= sel_eff;
            // level emitted now decides: a fresh high must finish
            state_r    <= (out_nxt && !hold_dead) ? GCM_WAIT_LOW
                                                  : GCM_WAIT_NEW;
          end
        end
        GCM_WAIT_LOW: begin
          if (!cur_lvl || hold_dead)
            state_r <= GCM_WAIT_NEW;
        end
        GCM_WAIT_NEW: begin
          if (new_fell) begin
            cur_sel_r <= pend_sel_r;
            state_r   <= GCM_RUN;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // output level
  // ------------------------------------------------------------
  always_comb begin
    out_nxt = out_r;
    if (!runt_suppress)
      out_nxt = pick(sel_eff, clk_in_a_i, clk_in_b_i);
    else if (!por_done_r)
      out_nxt = OUT_RST;
    else if (state_r == GCM_WAIT_NEW)
      out_nxt = 1'b0;
    else if (state_r == GCM_WAIT_LOW)
      out_nxt = cur_lvl;
    else if (!hold_dead)
      out_nxt = cur_lvl;
    // dead input: hold last level, no toggling
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_r              <= OUT_RST;
      clk_out_pair_a_p_o <= OUT_RST;
      clk_out_pair_a_n_o <= ~OUT_RST;
      clk_out_pair_b_p_o <= OUT_RST;
      clk_out_pair_b_n_o <= ~OUT_RST;
      dc_input_guard_o   <= 1'b0;
    end else begin
      out_r              <= out_nxt;
      clk_out_pair_a_p_o <= out_nxt;
      clk_out_pair_a_n_o <= ~out_nxt;
      clk_out_pair_b_p_o <= out_nxt;
      clk_out_pair_b_n_o <= ~out_nxt;
      dc_input_guard_o   <= dead && runt_suppress;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_pairs_equal;
    @(posedge mclk_i) disable iff (!arst_n_i)
      clk_out_pair_a_p_o == clk_out_pair_b_p_o;
  endproperty
  a_pairs_equal: assert property (p_pairs_equal)
    else $error("output pairs differ");

  property p_compl;
    @(posedge mclk_i) disable iff (!arst_n_i)
      clk_out_pair_a_p_o != clk_out_pair_a_n_o &&
      clk_out_pair_b_p_o != clk_out_pair_b_n_o;
  endproperty
  a_compl: assert property (p_compl)
    else $error("true and complement equal");

  property p_plain_mux;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (por_timing_pin_i && !sel_open_i) |=>
        clk_out_pair_a_p_o == ($past(sel_i) ? $past(clk_in_b_i)
                                            : $past(clk_in_a_i));
  endproperty
  a_plain_mux: assert property (p_plain_mux)
    else $error("plain selector output wrong");

  property p_open_sel;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (por_timing_pin_i && sel_open_i) |=>
        clk_out_pair_a_p_o == $past(clk_in_b_i);
  endproperty
  a_open_sel: assert property (p_open_sel)
    else $error("open select did not pick b");

  property p_park_low;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (state_r == GCM_WAIT_NEW && runt_suppress && por_done_r)
        |=> !clk_out_pair_a_p_o;
  endproperty
  a_park_low: assert property (p_park_low)
    else $error("output not parked low");

  property p_no_runt;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (runt_suppress && por_done_r && state_r == GCM_WAIT_NEW &&
       new_fell) |=> (state_r == GCM_RUN && cur_sel_r == $past(pend_sel_r));
  endproperty
  a_no_runt: assert property (p_no_runt)
    else $error("switch not taken at new low phase");

  property p_dead_hold;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (runt_suppress && por_done_r && state_r == GCM_RUN && hold_dead)
        |=> $stable(clk_out_pair_a_p_o);
  endproperty
  a_dead_hold: assert property (p_dead_hold)
    else $error("output toggled on dead input");

  property p_por;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (runt_suppress && !por_done_r) |=>
        (state_r == GCM_RUN && !clk_out_pair_a_p_o);
  endproperty
  a_por: assert property (p_por)
    else $error("state not held during power-on");

endmodule : gcm_clock_mux

//--- dv/gcm_clk_src.sv
// gcm_clk_src: two redundant clock sources for the selector
// assumes: sources toggle 1 ns after the mclk rising edge
`timescale 1ns/1ps
module gcm_clk_src (
  input  wire logic       mclk_i,
  input  wire logic [3:0] half_a_i,
  input  wire logic [3:0] half_b_i,
  input  wire logic       stop_a_i,
  input  wire logic       stop_b_i,
  output logic            clk_a_o,
  output logic            clk_b_o
);
  logic [3:0] cnt_a_r;
  logic [3:0] cnt_b_r;
  // one process owns both outputs: no second driver
  // a stopped source sits at dc, as a failed oscillator would
  initial begin
    clk_a_o = 1'b0;
    clk_b_o = 1'b1;
    cnt_a_r = 4'h0;
    cnt_b_r = 4'h0;
    forever begin
      @(posedge mclk_i);
      #1;
      cnt_a_r = stop_a_i ? 4'h0 : cnt_a_r + 4'h1;
      cnt_b_r = stop_b_i ? 4'h0 : cnt_b_r + 4'h1;
      if (cnt_a_r >= half_a_i) begin
        clk_a_o = ~clk_a_o;
        cnt_a_r = 4'h0;
      end
      if (cnt_b_r >= half_b_i) begin
        clk_b_o = ~clk_b_o;
        cnt_b_r = 4'h0;
      end
    end
  end
endmodule : gcm_clk_src

//--- dv/gcm_clock_mux_tb.sv
// gcm_clock_mux_tb: self-checking bench for the clock selector
// assumes: gcm_clk_src drives both clock inputs
`timescale 1ns/1ps
module gcm_clock_mux_tb;
  import gcm_pkg::*;
  logic       mclk, arst_n, sel, sel_open, por_pin, stop_a, stop_b;
  logic [3:0] half_a, half_b;
  logic       ca, cb, qa_p, qa_n, qb_p, qb_n, guard;
  int         num_errors, n_tests;
  gcm_clk_src src (.mclk_i(mclk), .half_a_i(half_a), .half_b_i(half_b),
    .stop_a_i(stop_a), .stop_b_i(stop_b), .clk_a_o(ca), .clk_b_o(cb));
  gcm_clock_mux dut (.mclk_i(mclk), .arst_n_i(arst_n), .clk_in_a_i(ca),
    .clk_in_b_i(cb), .sel_i(sel), .sel_open_i(sel_open),
    .por_timing_pin_i(por_pin), .clk_out_pair_a_p_o(qa_p),
    .clk_out_pair_a_n_o(qa_n), .clk_out_pair_b_p_o(qb_p),
    .clk_out_pair_b_n_o(qb_n), .dc_input_guard_o(guard));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic check(input string nm, input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : check
  // one-cycle latency: output shows input sampled at the edge before
  task automatic follow(input int n, input logic use_b);
    logic exp;
    repeat (n) begin
      exp = use_b ? cb : ca;
      @(posedge mclk);
      #2;
      check("qa_p", qa_p, exp);
      check("qa_n", qa_n, ~exp);
      check("qb_p", qb_p, qa_p);
      check("qb_n", qb_n, qa_n);
    end
  endtask : follow
  task automatic t_plain;
    por_pin = 1'b1;
    sel = SEL_A;
    follow(12, 1'b0);
    sel = SEL_B;
    follow(12, 1'b1);
    $display("plain mux done");
  endtask : t_plain
  task automatic t_open;
    sel = SEL_A;
    sel_open = 1'b1;
    follow(12, 1'b1);
    sel_open = 1'b0;
    $display("open select done");
  endtask : t_open
  task automatic t_por;
    por_pin = 1'b0;
    arst_n = 1'b0;
    #5;
    check("rst_n", qa_n, 1'b1);
    @(posedge mclk);
    #2 arst_n = 1'b1;
    repeat (POR_CYC) begin
      @(posedge mclk);
      #2 check("por_p", qb_p, 1'b0);
    end
    $display("power-on hold done");
  endtask : t_por
  // every high or low run must last at least the shorter half period
  task automatic t_switch;
    int len;
    logic last;
    logic seen;
    len = 0;
    last = qa_p;
    seen = 1'b0;
    for (int i = 0; i < 120; i++) begin
      @(posedge mclk);
      #2;
      if (i % 23 == 5) sel = ~sel;
      if (qa_p !== last) begin
        // the run in progress at entry is partial: not judged
        if (seen) check("run", len >= 3, 1'b1);
        seen = 1'b1;
        len = 0;
        last = qa_p;
      end
      len++;
    end
    $display("switchover done");
  endtask : t_switch
  task automatic t_dead;
    logic hold;
    sel = SEL_A;
    repeat (30) @(posedge mclk);
    #2 stop_a = 1'b1;
    repeat (DC_LIM + 4) @(posedge mclk);
    #2 hold = qa_p;
    check("guard", guard, 1'b1);
    repeat (8) begin
      @(posedge mclk);
      #2 check("dead_q", qa_p, hold);
    end
    stop_a = 1'b0;
    $display("dead input done");
  endtask : t_dead
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end
  initial begin
    {num_errors, n_tests} = '0;
    {arst_n, sel_open, stop_a, stop_b} = 4'h0;
    {sel, por_pin} = 2'b11;
    half_a = 4'h3;
    half_b = 4'h5;
    repeat (2) @(posedge mclk);
    #2 arst_n = 1'b1;
    t_plain();
    t_open();
    t_por();
    t_switch();
    t_dead();
    complete_run();
  end
endmodule : gcm_clock_mux_tb
